// ---- verilog/ioc_pkg.sv ----
// constants and types shared by the io cell output logic
package ioc_pkg;

  // ---------------------------------------------------------------
  // pad output function selection
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    IOC_FN_MUX_A_REG = 4'h0,  // mux_a_with_reg
    IOC_FN_MUX_B_REG = 4'h1,  // mux_b_with_reg
    IOC_FN_MUX_A_B   = 4'h2,  // mux_a_with_b
    IOC_FN_AND       = 4'h3,
    IOC_FN_NAND      = 4'h4,
    IOC_FN_OR        = 4'h5,
    IOC_FN_NOR       = 4'h6,
    IOC_FN_XOR       = 4'h7,
    IOC_FN_XNOR      = 4'h8
  } ioc_func_e;

  // ---------------------------------------------------------------
  // output flip-flop data source
  // ---------------------------------------------------------------
  localparam logic [1:0] IOC_DSEL_A = 2'h0;
  localparam logic [1:0] IOC_DSEL_B = 2'h1;
  localparam logic [1:0] IOC_DSEL_HI = 2'h2;
  localparam logic [1:0] IOC_DSEL_LO = 2'h3;

  // ---------------------------------------------------------------
  // bit positions in the set/reset value vector
  // ---------------------------------------------------------------
  localparam int IOC_SR_IN = 0;
  localparam int IOC_SR_OUT = 1;
  localparam int IOC_SR_TS = 2;
  localparam int IOC_SR_W = 3;

  // ---------------------------------------------------------------
  // pin synchroniser layout, storage and pad reset values
  // ---------------------------------------------------------------
  localparam int IOC_SYNC_SCLK = 0;
  localparam int IOC_SYNC_FCLK = 1;
  localparam int IOC_SYNC_PAD = 2;
  localparam int IOC_SYNC_N = 3;
  localparam logic IOC_Q_RST = 1'b0;
  localparam logic IOC_PAD_RST = 1'b0;

endpackage : ioc_pkg

// ---- verilog/ioc_store.sv ----
// one configurable latch / flip-flop of the io cell
`timescale 1ns/1ns
module ioc_store
  import ioc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic is_latch,
  input wire logic level,
  input wire logic clk_edge,
  input wire logic d,
  input wire logic ce_act,
  input wire logic lsr_act,
  input wire logic lsr_sync,
  input wire logic ce_over_lsr,
  input wire logic gsr_act,
  input wire logic sr_val,
  output logic q_reg
);

  // -------------------------------------------------------------
  // storage update
  // -------------------------------------------------------------
  // global and asynchronous local set/reset act without a clock edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= IOC_Q_RST;
    end else if (gsr_act) begin
      q_reg <= sr_val;
    end else if (lsr_act && !lsr_sync) begin
      q_reg <= sr_val;
    end else if (is_latch) begin
      // latch ignores clock enable entirely
      if (level) begin
        q_reg <= d;
      end
    end else if (clk_edge) begin
      if (ce_over_lsr) begin
        if (ce_act) begin
          q_reg <= lsr_act ? sr_val : d;
        end
      end else if (lsr_act) begin
        q_reg <= sr_val;
      end else if (ce_act) begin
        q_reg <= d;
      end
    end
  end

endmodule : ioc_store

// ---- verilog/ioc_output_logic.sv ----
// io cell output logic, register controls and clock selection
`timescale 1ns/1ns
module ioc_output_logic
  import ioc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sys_clk_pin,
  input wire logic fast_io_clk,
  input wire logic pad_in,
  input wire logic route_out_a,
  input wire logic route_out_b,
  input wire logic route_ts,
  input wire logic clk_en,
  input wire logic local_set_reset,
  input wire logic global_set_reset_n,
  input wire ioc_func_e cfg_func,
  input wire logic [1:0] cfg_ff_dsel,
  input wire logic cfg_ff_dinv,
  input wire logic cfg_out_clk_fast,
  input wire logic cfg_ts_clk_fast,
  input wire logic cfg_in_latch,
  input wire logic cfg_in_fast,
  input wire logic cfg_in_ce_en,
  input wire logic cfg_out_ce_en,
  input wire logic cfg_in_ce_inv,
  input wire logic cfg_out_ce_inv,
  input wire logic cfg_sclk_inv,
  input wire logic cfg_fclk_inv,
  input wire logic cfg_lsr_inv,
  input wire logic cfg_lsr_en,
  input wire logic cfg_gsr_inv,
  input wire logic cfg_gsr_en,
  input wire logic [IOC_SR_W-1:0] cfg_sr_val,
  input wire logic cfg_out_lsr_sync,
  input wire logic cfg_ce_over_lsr,
  output logic pad_out,
  output logic pad_oe,
  output logic fast_latch_q,
  output logic in_q,
  output logic out_ff_q,
  output logic ts_q
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [IOC_SYNC_N-1:0] pin_raw;
  logic [IOC_SYNC_N-1:0] s1_reg;
  logic [IOC_SYNC_N-1:0] s2_reg;
  logic [IOC_SYNC_N-1:0] s3_reg;
  logic [IOC_SYNC_N-1:0] stab_reg;

  assign pin_raw[IOC_SYNC_SCLK] = sys_clk_pin;
  assign pin_raw[IOC_SYNC_FCLK] = fast_io_clk;
  assign pin_raw[IOC_SYNC_PAD] = pad_in;

  // three stages; a change is taken only once stages two and three agree
  for (genvar g = 0; g < IOC_SYNC_N; g++) begin : g_sync
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_reg[g] <= 1'b0;
        s2_reg[g] <= 1'b0;
        s3_reg[g] <= 1'b0;
        stab_reg[g] <= 1'b0;
      end else begin
        s1_reg[g] <= pin_raw[g];
        s2_reg[g] <= s1_reg[g];
        s3_reg[g] <= s2_reg[g];
        if (s2_reg[g] == s3_reg[g]) begin
          stab_reg[g] <= s3_reg[g];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // control polarity and edge detection
  // ---------------------------------------------------------------
  logic sclk_lvl;
  logic fclk_lvl;
  logic pad_s;
  logic sclk_prev_reg;
  logic fclk_prev_reg;
  logic sclk_rise;
  logic fclk_rise;
  logic ce_in_act;
  logic ce_out_act;
  logic lsr_act;
  logic gsr_act;

  assign sclk_lvl = stab_reg[IOC_SYNC_SCLK] ^ cfg_sclk_inv;
  assign fclk_lvl = stab_reg[IOC_SYNC_FCLK] ^ cfg_fclk_inv;
  assign pad_s = stab_reg[IOC_SYNC_PAD];
  // history holds the raw pin, so an inversion set at reset gives no edge
  assign sclk_rise = sclk_lvl & ~(sclk_prev_reg ^ cfg_sclk_inv);
  assign fclk_rise = fclk_lvl & ~(fclk_prev_reg ^ cfg_fclk_inv);
  // separate enable polarity per path
  assign ce_in_act = ~cfg_in_ce_en | (clk_en ^ cfg_in_ce_inv);
  assign ce_out_act = ~cfg_out_ce_en | (clk_en ^ cfg_out_ce_inv);
  assign lsr_act = cfg_lsr_en & (local_set_reset ^ cfg_lsr_inv);
  assign gsr_act = cfg_gsr_en & ~(global_set_reset_n ^ cfg_gsr_inv);

  // previous raw clock pins for edge detection; same reset as the chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_reg <= 1'b0;
      fclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= stab_reg[IOC_SYNC_SCLK];
      fclk_prev_reg <= stab_reg[IOC_SYNC_FCLK];
    end
  end

  // ---------------------------------------------------------------
  // storage elements
  // ---------------------------------------------------------------
  logic in_d;
  logic out_d;
  logic out_edge;
  logic ts_edge;

  // zero-hold path feeds the input flip-flop from the fast latch
  assign in_d = cfg_in_fast ? fast_latch_q : pad_s;
  assign out_edge = cfg_out_clk_fast ? fclk_rise : sclk_rise;
  assign ts_edge = cfg_ts_clk_fast ? fclk_rise : sclk_rise;

  // output flip-flop data source with optional inversion
  always_comb begin
    unique case (cfg_ff_dsel)
      IOC_DSEL_A: out_d = route_out_a;
      IOC_DSEL_B: out_d = route_out_b;
      IOC_DSEL_HI: out_d = 1'b1;
      IOC_DSEL_LO: out_d = 1'b0;
    endcase
    out_d = out_d ^ cfg_ff_dinv;
  end

  // fast-capture latch, always on the fast clock
  ioc_store u_fast (
    .clk(clk), .rst_b(rst_b), .is_latch(1'b1), .level(fclk_lvl),
    .clk_edge(1'b0), .d(pad_s), .ce_act(1'b1), .lsr_act(lsr_act),
    .lsr_sync(1'b0), .ce_over_lsr(cfg_ce_over_lsr), .gsr_act(gsr_act),
    .sr_val(cfg_sr_val[IOC_SR_IN]), .q_reg(fast_latch_q)
  );

  // input latch or flip-flop on the system clock
  ioc_store u_in (
    .clk(clk), .rst_b(rst_b), .is_latch(cfg_in_latch), .level(sclk_lvl),
    .clk_edge(sclk_rise), .d(in_d), .ce_act(ce_in_act),
    .lsr_act(lsr_act), .lsr_sync(1'b0), .ce_over_lsr(cfg_ce_over_lsr),
    .gsr_act(gsr_act), .sr_val(cfg_sr_val[IOC_SR_IN]), .q_reg(in_q)
  );

  // output flip-flop; captures the leading value at the active edge
  ioc_store u_out (
    .clk(clk), .rst_b(rst_b), .is_latch(1'b0), .level(1'b0),
    .clk_edge(out_edge), .d(out_d), .ce_act(ce_out_act),
    .lsr_act(lsr_act), .lsr_sync(cfg_out_lsr_sync),
    .ce_over_lsr(cfg_ce_over_lsr), .gsr_act(gsr_act),
    .sr_val(cfg_sr_val[IOC_SR_OUT]), .q_reg(out_ff_q)
  );

  // 3-state flip-flop has no clock enable
  ioc_store u_ts (
    .clk(clk), .rst_b(rst_b), .is_latch(1'b0), .level(1'b0),
    .clk_edge(ts_edge), .d(route_ts), .ce_act(1'b1),
    .lsr_act(lsr_act), .lsr_sync(1'b0), .ce_over_lsr(cfg_ce_over_lsr),
    .gsr_act(gsr_act), .sr_val(cfg_sr_val[IOC_SR_TS]), .q_reg(ts_q)
  );

  // ---------------------------------------------------------------
  // pad output function
  // ---------------------------------------------------------------
  logic pad_next;

  // config is static, so the function select never glitches the pad
  always_comb begin
    unique case (cfg_func)
      IOC_FN_MUX_A_REG: pad_next = sclk_lvl ? out_ff_q : route_out_a;
      IOC_FN_MUX_B_REG: pad_next = sclk_lvl ? out_ff_q : route_out_b;
      IOC_FN_MUX_A_B: pad_next = sclk_lvl ? route_out_b : route_out_a;
      IOC_FN_AND: pad_next = route_out_b & sclk_lvl;
      IOC_FN_NAND: pad_next = ~(route_out_b & sclk_lvl);
      IOC_FN_OR: pad_next = route_out_b | sclk_lvl;
      IOC_FN_NOR: pad_next = ~(route_out_b | sclk_lvl);
      IOC_FN_XOR: pad_next = route_out_b ^ sclk_lvl;
      IOC_FN_XNOR: pad_next = ~(route_out_b ^ sclk_lvl);
      default: pad_next = IOC_PAD_RST;
    endcase
  end

  // registered pad data; enable follows the 3-state flip-flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_out <= IOC_PAD_RST;
    end else begin
      pad_out <= pad_next;
    end
  end
  assign pad_oe = ts_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_mux_a_reg;
    @(posedge clk) disable iff (!rst_b)
    cfg_func == IOC_FN_MUX_A_REG |=>
      pad_out == ($past(sclk_lvl) ? $past(out_ff_q) : $past(route_out_a));
  endproperty
  a_mux_a_reg: assert property (p_mux_a_reg) else $error("a/reg mux bad");

  property p_mux_b_reg;
    @(posedge clk) disable iff (!rst_b)
    cfg_func == IOC_FN_MUX_B_REG && sclk_lvl |=> pad_out == $past(out_ff_q);
  endproperty
  a_mux_b_reg: assert property (p_mux_b_reg) else $error("b/reg mux bad");

  property p_mux_a_b;
    @(posedge clk) disable iff (!rst_b)
    cfg_func == IOC_FN_MUX_A_B && !sclk_lvl |=> pad_out == $past(route_out_a);
  endproperty
  a_mux_a_b: assert property (p_mux_a_b) else $error("a/b mux bad");

  property p_xnor;
    @(posedge clk) disable iff (!rst_b)
    cfg_func == IOC_FN_XNOR |=>
      pad_out == ~($past(route_out_b) ^ $past(sclk_lvl));
  endproperty
  a_xnor: assert property (p_xnor) else $error("xnor output bad");

  property p_fast_latch;
    @(posedge clk) disable iff (!rst_b)
    fclk_lvl && !lsr_act && !gsr_act |=> fast_latch_q == $past(pad_s);
  endproperty
  a_fast_latch: assert property (p_fast_latch) else $error("fast latch");

  property p_out_capture;
    @(posedge clk) disable iff (!rst_b)
    out_edge && ce_out_act && !lsr_act && !gsr_act |=>
      out_ff_q == $past(out_d) ##1 1'b1;
  endproperty
  a_out_capture: assert property (p_out_capture) else $error("out ff");

  property p_ce_hold;
    @(posedge clk) disable iff (!rst_b)
    cfg_ce_over_lsr && !ce_out_act && cfg_out_lsr_sync && !gsr_act
      |=> $stable(out_ff_q);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("ce priority");

  property p_gsr;
    @(posedge clk) disable iff (!rst_b)
    gsr_act |=> out_ff_q == $past(cfg_sr_val[IOC_SR_OUT])
      && ts_q == $past(cfg_sr_val[IOC_SR_TS]);
  endproperty
  a_gsr: assert property (p_gsr) else $error("global set/reset");

  property p_lsr_async;
    @(posedge clk) disable iff (!rst_b)
    lsr_act && !cfg_out_lsr_sync |=> out_ff_q == $past(cfg_sr_val[IOC_SR_OUT]);
  endproperty
  a_lsr_async: assert property (p_lsr_async) else $error("async lsr");

  c_mux_b_reg: cover property (@(posedge clk) disable iff (!rst_b)
    cfg_func == IOC_FN_MUX_B_REG && sclk_rise);
  c_fast_out: cover property (@(posedge clk) disable iff (!rst_b)
    cfg_out_clk_fast && fclk_rise && ce_out_act);
  c_gsr: cover property (@(posedge clk) disable iff (!rst_b) gsr_act);

endmodule : ioc_output_logic

// ---- test/ioc_far_end.sv ----
// model of the pad and the clock pins beyond the io cell
`timescale 1ns/1ns
module ioc_far_end (
  input wire logic clk,
  input wire logic sclk_lvl,
  input wire logic fclk_lvl,
  input wire logic pad_out,
  input wire logic pad_oe,
  output logic sys_clk_pin,
  output logic fast_io_clk,
  output logic pad_in
);
  // ---------------------------------------------------------------
  // clock pins and pad
  // ---------------------------------------------------------------
  // pins move only on a core edge, so the bench always knows the phase
  always_ff @(posedge clk) begin
    sys_clk_pin <= sclk_lvl;
    fast_io_clk <= fclk_lvl;
  end
  // a released pad is held by its pull-up, never by its last value
  assign pad_in = pad_oe ? pad_out : 1'b1;
endmodule : ioc_far_end

// ---- test/tb_io_cell_output_logic_and_controls.sv ----
// self-checking bench for the io cell output logic and controls
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %b exp %b", $time, g, e); end end
module tb_io_cell_output_logic_and_controls
  import ioc_pkg::*;
();
  logic clk = 1'b0;
  logic rst_b, sclk_lvl, fclk_lvl, sys_clk_pin, fast_io_clk, pad_in;
  logic route_out_a, route_out_b, route_ts, clk_en, local_set_reset;
  logic global_set_reset_n, cfg_ff_dinv, cfg_out_clk_fast, cfg_ts_clk_fast;
  logic cfg_in_latch, cfg_in_fast, cfg_in_ce_en, cfg_out_ce_en;
  logic cfg_in_ce_inv, cfg_out_ce_inv, cfg_sclk_inv, cfg_fclk_inv;
  logic cfg_lsr_inv, cfg_lsr_en, cfg_gsr_inv, cfg_gsr_en;
  logic cfg_out_lsr_sync, cfg_ce_over_lsr;
  logic pad_out, pad_oe, fast_latch_q, in_q, out_ff_q, ts_q;
  ioc_func_e cfg_func;
  logic [1:0] cfg_ff_dsel;
  logic [IOC_SR_W-1:0] cfg_sr_val;
  int n_fail = 0;
  int n_tests = 0;

  ioc_output_logic uut (.clk, .rst_b, .sys_clk_pin, .fast_io_clk, .pad_in,
    .route_out_a, .route_out_b, .route_ts, .clk_en, .local_set_reset,
    .global_set_reset_n, .cfg_func, .cfg_ff_dsel, .cfg_ff_dinv,
    .cfg_out_clk_fast, .cfg_ts_clk_fast, .cfg_in_latch, .cfg_in_fast,
    .cfg_in_ce_en, .cfg_out_ce_en, .cfg_in_ce_inv, .cfg_out_ce_inv,
    .cfg_sclk_inv, .cfg_fclk_inv, .cfg_lsr_inv, .cfg_lsr_en, .cfg_gsr_inv,
    .cfg_gsr_en, .cfg_sr_val, .cfg_out_lsr_sync, .cfg_ce_over_lsr,
    .pad_out, .pad_oe, .fast_latch_q, .in_q, .out_ff_q, .ts_q);
  ioc_far_end far (.clk, .sclk_lvl, .fclk_lvl, .pad_out, .pad_oe,
    .sys_clk_pin, .fast_io_clk, .pad_in);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  always #10 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // 8 cycles covers the pin synchroniser plus the output register
  task automatic sclk(input logic v);
    sclk_lvl <= v;
    cyc(8);
  endtask : sclk

  task automatic fclk(input logic v);
    fclk_lvl <= v;
    cyc(8);
  endtask : fclk

  task automatic rst_all;
    {route_out_a, route_out_b, route_ts, clk_en, local_set_reset,
      cfg_ff_dinv, cfg_out_clk_fast, cfg_ts_clk_fast, cfg_in_latch,
      cfg_in_fast, cfg_in_ce_en, cfg_out_ce_en, cfg_in_ce_inv,
      cfg_out_ce_inv, cfg_sclk_inv, cfg_fclk_inv, cfg_lsr_inv, cfg_lsr_en,
      cfg_gsr_inv, cfg_gsr_en, cfg_out_lsr_sync, cfg_ce_over_lsr,
      sclk_lvl, fclk_lvl} <= '0;
    cfg_func <= IOC_FN_MUX_A_REG;
    cfg_ff_dsel <= IOC_DSEL_HI;
    cfg_sr_val <= '0;
    global_set_reset_n <= 1'b1;
    rst_b <= 1'b0;
    cyc(4);
    rst_b <= 1'b1;
    cyc(8);
  endtask : rst_all

  function automatic logic exp_fn(input int f, input logic b, input logic c);
    case (f)
      3: return b & c;
      4: return ~(b & c);
      5: return b | c;
      6: return ~(b | c);
      7: return b ^ c;
      default: return ~(b ^ c);
    endcase
  endfunction : exp_fn

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_mux;
    rst_all();
    `CHK({pad_out, out_ff_q, in_q, ts_q, pad_oe}, 5'h00)
    cfg_ff_dsel <= IOC_DSEL_A;
    route_out_a <= 1'b1;
    sclk(1);
    route_out_a <= 1'b0;
    cyc(8);
    `CHK({out_ff_q, pad_out}, 2'h3)
    sclk(0);
    `CHK(pad_out, 1'b0)
    cfg_func <= IOC_FN_MUX_B_REG;
    route_out_b <= 1'b1;
    cyc(8);
    `CHK(pad_out, 1'b1)
    sclk(1);
    `CHK(pad_out, 1'b0)
    cfg_func <= IOC_FN_MUX_A_B;
    cyc(8);
    `CHK(pad_out, 1'b1)
    sclk(0);
    `CHK(pad_out, 1'b0)
    // inverted system clock turns the low pin into the high phase
    cfg_sclk_inv <= 1'b1;
    cyc(8);
    `CHK(pad_out, 1'b1)
  endtask : t_mux

  task automatic t_logic;
    rst_all();
    for (int f = 3; f <= 8; f++) begin
      for (int k = 0; k < 4; k++) begin
        cfg_func <= ioc_func_e'(f);
        route_out_b <= k[0];
        sclk(k[1]);
        `CHK(pad_out, exp_fn(f, k[0], k[1]))
      end
    end
  endtask : t_logic

  task automatic t_dsel;
    logic e;
    rst_all();
    route_out_a <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      for (int i = 0; i < 2; i++) begin
        cfg_ff_dsel <= d[1:0];
        cfg_ff_dinv <= i[0];
        e = (d == IOC_DSEL_A || d == IOC_DSEL_HI) ^ i[0];
        sclk(1);
        sclk(0);
        `CHK(out_ff_q, e)
      end
    end
  endtask : t_dsel

  // enable inactive: latch still follows, output flip-flop holds
  task automatic t_ce;
    rst_all();
    cfg_in_latch <= 1'b1;
    cfg_in_ce_en <= 1'b1;
    cfg_out_ce_en <= 1'b1;
    sclk(1);
    `CHK({in_q, out_ff_q}, 2'h2)
    rst_all();
    cfg_in_ce_en <= 1'b1;
    cfg_out_ce_en <= 1'b1;
    cfg_in_ce_inv <= 1'b1;
    cfg_func <= IOC_FN_OR;
    route_out_b <= 1'b1;
    route_ts <= 1'b1;
    sclk(1);
    sclk(0);
    `CHK({in_q, out_ff_q, ts_q}, 3'h5)
    clk_en <= 1'b1;
    sclk(1);
    `CHK(out_ff_q, 1'b1)
  endtask : t_ce

  task automatic t_lsr;
    rst_all();
    cfg_lsr_en <= 1'b1;
    cfg_sr_val <= 3'h7;
    local_set_reset <= 1'b1;
    cyc(8);
    `CHK({fast_latch_q, in_q, out_ff_q, ts_q}, 4'hf)
    cfg_sr_val <= 3'h5;
    cfg_lsr_inv <= 1'b1;
    cyc(8);
    `CHK(out_ff_q, 1'b1)
    local_set_reset <= 1'b0;
    cyc(8);
    `CHK({fast_latch_q, in_q, out_ff_q, ts_q}, 4'hd)
    cfg_lsr_en <= 1'b0;
    cfg_sr_val <= 3'h2;
    cyc(8);
    `CHK(out_ff_q, 1'b0)
    cfg_lsr_en <= 1'b1;
    cfg_out_lsr_sync <= 1'b1;
    cyc(8);
    `CHK(out_ff_q, 1'b0)
    sclk(1);
    `CHK(out_ff_q, 1'b1)
    sclk(0);
    cfg_sr_val <= 3'h0;
    cfg_out_ce_en <= 1'b1;
    cfg_ce_over_lsr <= 1'b1;
    sclk(1);
    `CHK(out_ff_q, 1'b1)
    sclk(0);
    cfg_ce_over_lsr <= 1'b0;
    sclk(1);
    `CHK(out_ff_q, 1'b0)
  endtask : t_lsr

  task automatic t_gsr;
    rst_all();
    cfg_gsr_en <= 1'b1;
    cfg_sr_val <= 3'h6;
    global_set_reset_n <= 1'b0;
    cyc(8);
    `CHK({in_q, out_ff_q, ts_q}, 3'h3)
    global_set_reset_n <= 1'b1;
    cfg_gsr_en <= 1'b0;
    cfg_sr_val <= 3'h0;
    cyc(8);
    global_set_reset_n <= 1'b0;
    cyc(8);
    `CHK({out_ff_q, ts_q}, 2'h3)
    cfg_gsr_en <= 1'b1;
    cfg_gsr_inv <= 1'b1;
    cyc(8);
    `CHK({out_ff_q, ts_q}, 2'h3)
    global_set_reset_n <= 1'b1;
    cyc(8);
    `CHK({out_ff_q, ts_q}, 2'h0)
  endtask : t_gsr

  // pad held high by an OR so the fast latch sees a steady level
  task automatic t_fast;
    rst_all();
    cfg_out_clk_fast <= 1'b1;
    cfg_ts_clk_fast <= 1'b1;
    cfg_in_fast <= 1'b1;
    cfg_func <= IOC_FN_OR;
    route_out_b <= 1'b1;
    route_ts <= 1'b1;
    sclk(1);
    sclk(0);
    `CHK({fast_latch_q, in_q, out_ff_q, ts_q, pad_oe}, 5'h00)
    fclk(1);
    `CHK({fast_latch_q, in_q, out_ff_q, ts_q, pad_oe}, 5'h17)
    // input flip-flop now takes the fast latch on the system clock
    sclk(1);
    `CHK(in_q, 1'b1)
    // inverted fast clock: the falling pin is the active edge
    route_ts <= 1'b0;
    cfg_fclk_inv <= 1'b1;
    fclk(0);
    `CHK({ts_q, pad_oe}, 2'h0)
  endtask : t_fast

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  initial begin
    t_mux();
    t_logic();
    t_dsel();
    t_ce();
    t_lsr();
    t_gsr();
    t_fast();
    wrap_up();
  end

  // whole run is about 670 cycles; this is over seven times that
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
endmodule : tb_io_cell_output_logic_and_controls
